/* design/csfw_pkg.sv */
/*
  csfw_pkg: register offsets, bit positions, reset values and timebase
  counts for the controller system flag words.
  Assumes a 100 MHz system clock; byte addresses are word aligned.
*/
package csfw_pkg;

  // bus word addresses
  localparam logic [7:0] CSFW_OFS_PULSE = 8'h00;
  localparam logic [7:0] CSFW_OFS_RUN   = 8'h04;
  localparam logic [7:0] CSFW_OFS_PORT1 = 8'h08;
  localparam logic [7:0] CSFW_OFS_ALIAS = 8'h0C;
  localparam logic [7:0] CSFW_OFS_CTRL  = 8'h10;

  // timebase and scan pulse word
  localparam int CSFW_B_CONST_HIGH  = 0;
  localparam int CSFW_B_CONST_LOW   = 1;
  localparam int CSFW_B_SCAN_TOGGLE = 2;
  localparam int CSFW_B_FIRST_HIGH  = 3;
  localparam int CSFW_B_FIRST_LOW   = 4;
  localparam int CSFW_B_STEP_START  = 5;
  localparam int CSFW_B_TICK_BASE   = 8;
  localparam int CSFW_NUM_TICKS     = 7;

  // run and trace status word
  localparam int CSFW_B_RUN_MODE    = 0;
  localparam int CSFW_B_MESSAGE     = 6;
  localparam int CSFW_B_OVERRIDE    = 9;
  localparam int CSFW_B_INT_ARMED   = 10;
  localparam int CSFW_B_SAMPLE_METH = 12;
  localparam int CSFW_B_TRACE_FIN   = 13;
  localparam int CSFW_B_TRACE_HALT  = 14;
  localparam int CSFW_B_TRACE_ACT   = 15;

  // port one communication word and its alias word
  localparam int CSFW_B_GEN_MODE    = 2;
  localparam int CSFW_B_PRINT_BUSY  = 3;
  localparam int CSFW_B_ONLINE_EDIT = 4;
  localparam int CSFW_B_LINK_FAULT  = 7;
  localparam int CSFW_B_RX_DONE     = 8;
  localparam int CSFW_B_TX_DONE     = 9;
  localparam int CSFW_A_LINK_FAULT  = 8;
  localparam int CSFW_A_GEN_MODE    = 9;
  localparam int CSFW_A_RX_DONE     = 10;
  localparam int CSFW_A_TX_DONE     = 11;

  // control register fields and reset value
  localparam int         CSFW_C_SAMPLE_METH = 0;
  localparam int         CSFW_C_GEN_MODE    = 1;
  localparam logic [1:0] CSFW_CTRL_RESET    = 2'h0;

  // timebase periods in ms, halved into cycles for a 50 percent duty
  localparam longint CSFW_CLK_PERIOD_NS = 10;
  localparam longint CSFW_NS_PER_MS     = 1000000;
  localparam longint CSFW_TICK_10MS_MS  = 10;
  localparam longint CSFW_TICK_20MS_MS  = 20;
  localparam longint CSFW_TICK_100MS_MS = 100;
  localparam longint CSFW_TICK_200MS_MS = 200;
  localparam longint CSFW_TICK_1S_MS    = 1000;
  localparam longint CSFW_TICK_2S_MS    = 2000;
  localparam longint CSFW_TICK_1MIN_MS  = 60000;
  localparam longint CSFW_HALF_DIV      = 2 * CSFW_CLK_PERIOD_NS;
  localparam int unsigned CSFW_HALF_10MS  =
    32'(CSFW_TICK_10MS_MS * CSFW_NS_PER_MS / CSFW_HALF_DIV);
  localparam int unsigned CSFW_HALF_20MS  =
    32'(CSFW_TICK_20MS_MS * CSFW_NS_PER_MS / CSFW_HALF_DIV);
  localparam int unsigned CSFW_HALF_100MS =
    32'(CSFW_TICK_100MS_MS * CSFW_NS_PER_MS / CSFW_HALF_DIV);
  localparam int unsigned CSFW_HALF_200MS =
    32'(CSFW_TICK_200MS_MS * CSFW_NS_PER_MS / CSFW_HALF_DIV);
  localparam int unsigned CSFW_HALF_1S    =
    32'(CSFW_TICK_1S_MS * CSFW_NS_PER_MS / CSFW_HALF_DIV);
  localparam int unsigned CSFW_HALF_2S    =
    32'(CSFW_TICK_2S_MS * CSFW_NS_PER_MS / CSFW_HALF_DIV);
  localparam int unsigned CSFW_HALF_1MIN  =
    32'(CSFW_TICK_1MIN_MS * CSFW_NS_PER_MS / CSFW_HALF_DIV);

endpackage

/* design/csfw_tick_gen.sv */
/*
  csfw_tick_gen: one free-running square wave, toggling every HALF_CYCLES
  clocks. Assumes a single system clock and an active-low async reset.
*/
`timescale 1ns/1ps
module csfw_tick_gen #(
  parameter int unsigned HALF_CYCLES = 32'd500000
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // square wave out
  output logic      tick
);
  import csfw_pkg::*;

  logic [31:0] count_reg;

  // a zero half period would wrap its compare value to all ones, 2^32 clocks per toggle
  if (HALF_CYCLES < 1) begin : g_bad_half
    $error("csfw_tick_gen: HALF_CYCLES must be at least 1");
  end

  // free counter, never reloaded by scans so ticks stay scan independent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= 32'h0;
      tick      <= 1'b0;
    end else if (count_reg == 32'(HALF_CYCLES - 1)) begin
      count_reg <= 32'h0;
      tick      <= ~tick;
    end else begin
      count_reg <= count_reg + 32'h1;
    end
  end

endmodule // csfw_tick_gen

/* design/csfw_top.sv */
/*
  csfw_top: system flag words of a controller, read over AHB-Lite.
  Assumes event inputs come from logic on hclk as one-cycle pulses or
  levels; only the mode selector pin is asynchronous.
*/
// Function
// - scan toggle bit inverts at the start of every scan
// - first-scan-high bit is set only for the first scan after start
// - first-scan-low bit is clear only for the first scan after start
// - step start pulse lasts one scan after a step process starts
// - 10 ms and 20 ms free-running timebase pulse bits
// - 100 ms and 200 ms free-running timebase pulse bits
// - 1 s and 2 s free-running timebase pulse bits
// - 1 min free-running timebase pulse bit
// - run mode bit follows the mode selector, low in programming position
// - message shown bit sets when the message display instruction runs
// - override active bit is high while forcing is in progress
// - interrupt armed bit follows the external interrupt enable
// - sample method bit: 0 by instruction, 1 by constant interval
// - trace finished bit sets on sampling stop, clears on start
// - trace halt trigger bit follows the sampling stop trigger
// - trace active bit sets on sampling start, clears on stop
// - port one general mode bit shows general-purpose use
// - print busy bit is high while a print instruction executes
// - online edit bit lasts the first scan after a run-mode rewrite
// - link fault sets on transmit error, clears on transmit request
// - receive complete sets on end code in general-purpose mode
// - transmit complete sets at transmit end in general-purpose mode, clears on new request
// - port one link fault, receive and transmit complete bits change as events occur, not at scan boundaries
// - alias bits mirror their port one flags at all times
`timescale 1ns/1ps
module csfw_top
  import csfw_pkg::*;
#(
  parameter int unsigned HALF_10MS  = csfw_pkg::CSFW_HALF_10MS,
  parameter int unsigned HALF_20MS  = csfw_pkg::CSFW_HALF_20MS,
  parameter int unsigned HALF_100MS = csfw_pkg::CSFW_HALF_100MS,
  parameter int unsigned HALF_200MS = csfw_pkg::CSFW_HALF_200MS,
  parameter int unsigned HALF_1S    = csfw_pkg::CSFW_HALF_1S,
  parameter int unsigned HALF_2S    = csfw_pkg::CSFW_HALF_2S,
  parameter int unsigned HALF_1MIN  = csfw_pkg::CSFW_HALF_1MIN
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // scan sequencing
  input  wire logic        scan_start,
  input  wire logic        op_start,
  input  wire logic        step_process_start,
  input  wire logic        rewrite_done,
  // mode selector pin, high selects run
  input  wire logic        mode_run_pin,
  // program status
  input  wire logic        message_display_instruction,
  input  wire logic        force_in_progress,
  input  wire logic        ext_int_enabled,
  input  wire logic        print_executing,
  // sampling trace
  input  wire logic        trace_start,
  input  wire logic        trace_stop,
  input  wire logic        trace_stop_trigger,
  // serial port one events
  input  wire logic        tx_error,
  input  wire logic        transmit_request_op,
  input  wire logic        rx_end_code,
  input  wire logic        tx_end
);

  logic [1:0]  ctrl_reg;
  logic        scan_toggle_bit;
  logic        first_scan_high_bit;
  logic        first_pending_reg;
  logic        step_start_pulse_bit;
  logic        step_pending_reg;
  logic        online_edit_bit;
  logic        edit_pending_reg;
  logic [2:0]  mode_sync_reg;
  logic        run_mode_bit;
  logic        message_shown_bit;
  logic        override_active_bit;
  logic        interrupt_armed_bit;
  logic        print_busy_bit;
  logic        trace_finished_bit;
  logic        trace_halt_trigger_bit;
  logic        trace_active_bit;
  logic        port_one_link_fault_bit;
  logic        port_one_receive_complete_bit;
  logic        port_one_transmit_complete_bit;
  logic [CSFW_NUM_TICKS-1:0] ticks;
  logic [15:0] pulse_word;
  logic [15:0] run_word;
  logic [15:0] port_word;
  logic [15:0] alias_word;
  logic        addr_ok;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rd_next;

  localparam int unsigned HALF_CNT [CSFW_NUM_TICKS] = '{
    HALF_10MS, HALF_20MS, HALF_100MS, HALF_200MS, HALF_1S, HALF_2S, HALF_1MIN};

  // one divider per timebase bit; all free running off hclk
  for (genvar i = 0; i < CSFW_NUM_TICKS; i++) begin : g_tick
    csfw_tick_gen #(.HALF_CYCLES(HALF_CNT[i])) u_tick (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (ticks[i])
    );
  end

  // scan toggle flips at every scan start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) scan_toggle_bit <= 1'b0;
    else if (scan_start) scan_toggle_bit <= ~scan_toggle_bit;
  end

  // first scan: armed by operation start, taken by the next scan start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_pending_reg   <= 1'b1;
      first_scan_high_bit <= 1'b0;
    end else if (op_start) begin
      first_pending_reg   <= 1'b1;
      first_scan_high_bit <= 1'b0;
    end else if (scan_start) begin
      first_scan_high_bit <= first_pending_reg;
      first_pending_reg   <= 1'b0;
    end
  end

  // step start: a process start during a scan shows for the whole next scan
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_pending_reg     <= 1'b0;
      step_start_pulse_bit <= 1'b0;
    end else if (scan_start) begin
      step_start_pulse_bit <= step_pending_reg | step_process_start;
      step_pending_reg     <= 1'b0;
    end else if (step_process_start) begin
      step_pending_reg <= 1'b1;
    end
  end

  // online edit: rewrite completed in run mode, shown for the next scan
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edit_pending_reg <= 1'b0;
      online_edit_bit  <= 1'b0;
    end else if (scan_start) begin
      online_edit_bit  <= edit_pending_reg | (rewrite_done & run_mode_bit);
      edit_pending_reg <= 1'b0;
    end else if (rewrite_done && run_mode_bit) begin
      edit_pending_reg <= 1'b1;
    end
  end

  // mode selector pin: three stages, accepted when the last two agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_sync_reg <= 3'h0;
      run_mode_bit  <= 1'b0;
    end else begin
      mode_sync_reg <= {mode_sync_reg[1:0], mode_run_pin};
      if (mode_sync_reg[1] == mode_sync_reg[2]) run_mode_bit <= mode_sync_reg[2];
    end
  end

  // status levels; message flag sticks until operation restarts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      message_shown_bit   <= 1'b0;
      override_active_bit <= 1'b0;
      interrupt_armed_bit <= 1'b0;
      print_busy_bit      <= 1'b0;
    end else begin
      if (message_display_instruction) message_shown_bit <= 1'b1;
      else if (op_start) message_shown_bit <= 1'b0;
      override_active_bit <= force_in_progress;
      interrupt_armed_bit <= ext_int_enabled;
      print_busy_bit      <= print_executing;
    end
  end

  // sampling trace; a stop in the same cycle as a start wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trace_active_bit       <= 1'b0;
      trace_finished_bit     <= 1'b0;
      trace_halt_trigger_bit <= 1'b0;
    end else begin
      trace_halt_trigger_bit <= trace_stop_trigger;
      if (trace_stop) begin
        trace_active_bit   <= 1'b0;
        trace_finished_bit <= 1'b1;
      end else if (trace_start) begin
        trace_active_bit   <= 1'b1;
        trace_finished_bit <= 1'b0;
      end
    end
  end

  // port one flags move on the event itself, not on scans; set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_one_link_fault_bit        <= 1'b0;
      port_one_receive_complete_bit  <= 1'b0;
      port_one_transmit_complete_bit <= 1'b0;
    end else begin
      if (tx_error) port_one_link_fault_bit <= 1'b1;
      else if (transmit_request_op) port_one_link_fault_bit <= 1'b0;
      if (rx_end_code && ctrl_reg[CSFW_C_GEN_MODE])
        port_one_receive_complete_bit <= 1'b1;
      else if (transmit_request_op) port_one_receive_complete_bit <= 1'b0;
      if (tx_end && ctrl_reg[CSFW_C_GEN_MODE])
        port_one_transmit_complete_bit <= 1'b1;
      else if (transmit_request_op) port_one_transmit_complete_bit <= 1'b0;
    end
  end

  // word assembly; everything not placed stays zero
  always_comb begin
    pulse_word = 16'h0000;
    pulse_word[CSFW_B_CONST_HIGH]  = 1'b1;
    pulse_word[CSFW_B_CONST_LOW]   = 1'b0;
    pulse_word[CSFW_B_SCAN_TOGGLE] = scan_toggle_bit;
    pulse_word[CSFW_B_FIRST_HIGH]  = first_scan_high_bit;
    pulse_word[CSFW_B_FIRST_LOW]   = ~first_scan_high_bit;
    pulse_word[CSFW_B_STEP_START]  = step_start_pulse_bit;
    pulse_word[CSFW_B_TICK_BASE +: CSFW_NUM_TICKS] = ticks;
    run_word = 16'h0000;
    run_word[CSFW_B_RUN_MODE]    = run_mode_bit;
    run_word[CSFW_B_MESSAGE]     = message_shown_bit;
    run_word[CSFW_B_OVERRIDE]    = override_active_bit;
    run_word[CSFW_B_INT_ARMED]   = interrupt_armed_bit;
    run_word[CSFW_B_SAMPLE_METH] = ctrl_reg[CSFW_C_SAMPLE_METH];
    run_word[CSFW_B_TRACE_FIN]   = trace_finished_bit;
    run_word[CSFW_B_TRACE_HALT]  = trace_halt_trigger_bit;
    run_word[CSFW_B_TRACE_ACT]   = trace_active_bit;
    port_word = 16'h0000;
    port_word[CSFW_B_GEN_MODE]    = ctrl_reg[CSFW_C_GEN_MODE];
    port_word[CSFW_B_PRINT_BUSY]  = print_busy_bit;
    port_word[CSFW_B_ONLINE_EDIT] = online_edit_bit;
    port_word[CSFW_B_LINK_FAULT]  = port_one_link_fault_bit;
    port_word[CSFW_B_RX_DONE]     = port_one_receive_complete_bit;
    port_word[CSFW_B_TX_DONE]     = port_one_transmit_complete_bit;
    alias_word = 16'h0000;
    alias_word[CSFW_A_LINK_FAULT] = port_one_link_fault_bit;
    alias_word[CSFW_A_GEN_MODE]   = ctrl_reg[CSFW_C_GEN_MODE];
    alias_word[CSFW_A_RX_DONE]    = port_one_receive_complete_bit;
    alias_word[CSFW_A_TX_DONE]    = port_one_transmit_complete_bit;
  end

  // read mux, sampled in the address phase so hrdata leaves a flop
  always_comb begin
    if (haddr[7:0] == CSFW_OFS_PULSE) rd_next = {16'h0000, pulse_word};
    else if (haddr[7:0] == CSFW_OFS_RUN) rd_next = {16'h0000, run_word};
    else if (haddr[7:0] == CSFW_OFS_PORT1) rd_next = {16'h0000, port_word};
    else if (haddr[7:0] == CSFW_OFS_ALIAS) rd_next = {16'h0000, alias_word};
    else if (haddr[7:0] == CSFW_OFS_CTRL) rd_next = {30'h0, ctrl_reg};
    else rd_next = 32'h0000_0000;
  end

  // upper address bits must be zero for a hit; unmapped reads give zero
  assign addr_ok = (haddr[31:8] == 24'h00_0000);

  // zero-wait slave: address phase captured, write applied in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend_reg <= hsel & htrans[1] & hwrite & addr_ok;
        wr_addr_reg <= haddr[7:0];
        if (hsel && htrans[1] && !hwrite) hrdata <= addr_ok ? rd_next : 32'h0000_0000;
      end
    end
  end

  // control register: only the two low bits are kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_reg <= CSFW_CTRL_RESET;
    else if (wr_pend_reg && wr_addr_reg == CSFW_OFS_CTRL) ctrl_reg <= hwdata[1:0];
  end

  a_toggle_flip: assert property (@(posedge hclk) disable iff (!hresetn)
    scan_start |=> scan_toggle_bit != $past(scan_toggle_bit))
    else $error("scan toggle did not flip at scan start");

  a_first_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    scan_start && !op_start && !first_pending_reg |=> !first_scan_high_bit)
    else $error("first scan bit held past the first scan");

  a_first_low: assert property (@(posedge hclk) disable iff (!hresetn)
    scan_start && !op_start && first_pending_reg |=> !pulse_word[CSFW_B_FIRST_LOW])
    else $error("first scan low bit not clear in the first scan");

  a_step_once: assert property (@(posedge hclk) disable iff (!hresetn)
    scan_start && !step_pending_reg && !step_process_start |=> !step_start_pulse_bit)
    else $error("step start pulse lasted past one scan");

  a_run_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(mode_run_pin) ##1 mode_run_pin [*3] |=> run_mode_bit)
    else $error("run mode bit did not follow the selector");

  a_fault_set: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_error ##1 !transmit_request_op [*2] |=> port_one_link_fault_bit)
    else $error("link fault not held after transmit error");

  a_txdone_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    transmit_request_op && !tx_end |=> !port_one_transmit_complete_bit)
    else $error("transmit complete not cleared by request");

  a_trace_excl: assert property (@(posedge hclk) disable iff (!hresetn)
    trace_start && !trace_stop |=> trace_active_bit && !trace_finished_bit)
    else $error("trace start did not set active and clear finished");

  a_alias_eq: assert property (@(posedge hclk) disable iff (!hresetn)
    alias_word[CSFW_A_TX_DONE:CSFW_A_LINK_FAULT] ==
    {port_word[CSFW_B_TX_DONE], port_word[CSFW_B_RX_DONE],
     port_word[CSFW_B_GEN_MODE], port_word[CSFW_B_LINK_FAULT]})
    else $error("alias word differs from port one word");

  a_ctrl_read: assert property (@(posedge hclk) disable iff (!hresetn)
    hready && hsel && htrans[1] && !hwrite && haddr == 32'(CSFW_OFS_RUN) |=>
    hrdata[CSFW_B_SAMPLE_METH] == $past(ctrl_reg[CSFW_C_SAMPLE_METH]))
    else $error("sample method bit does not show control setting");

endmodule // csfw_top

/* verification/csfw_top_test.sv */
/*
  csfw_top_test: bus-level bench for the controller system flag words.
  Assumes csfw_top as the only AHB-Lite slave, shortened tick half periods,
  and event inputs driven as one-cycle pulses or levels on hclk.
*/
`timescale 1ns/1ps
module csfw_top_test;
  import csfw_pkg::*;

  // shortened half periods keep the run near 24k cycles
  localparam int unsigned H[7] = '{10, 20, 100, 200, 1000, 2000, 6000};

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] ev;
  logic [31:0] rd;
  int          bad_count;
  int          comparisons;
  int          scans;

  csfw_top #(
    .HALF_10MS(H[0]), .HALF_20MS(H[1]), .HALF_100MS(H[2]), .HALF_200MS(H[3]),
    .HALF_1S(H[4]), .HALF_2S(H[5]), .HALF_1MIN(H[6])
  ) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .scan_start(ev[0]), .op_start(ev[1]), .step_process_start(ev[2]),
    .rewrite_done(ev[3]), .mode_run_pin(ev[4]), .message_display_instruction(ev[5]),
    .force_in_progress(ev[6]), .ext_int_enabled(ev[7]), .print_executing(ev[8]),
    .trace_start(ev[9]), .trace_stop(ev[10]), .trace_stop_trigger(ev[11]),
    .tx_error(ev[12]), .transmit_request_op(ev[13]), .rx_end_code(ev[14]),
    .tx_end(ev[15])
  );

  // free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // masked word compare, unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    comparisons++;
    if ((got & mask) !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got & mask, exp);
    end
  endtask

  // one single transfer; entered and left just after a rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    // zero-wait slave must answer ready and OKAY
    chk({30'h0, hreadyout, hresp}, 32'h2, 32'h3);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp, mask);
  endtask

  // one-cycle event, then settle time before the next bus read
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev[i] <= 1'b0;
    @(posedge hclk);
    @(posedge hclk);
  endtask

  task automatic lvl(input int i, input logic v);
    ev[i] <= v;
    repeat (3) @(posedge hclk);
  endtask

  task automatic scan;
    pulse(0);
    scans++;
  endtask

  // port word bits 9..7 and their alias bits 11,10,8
  task automatic comm(input logic f, input logic r, input logic t);
    rdchk(CSFW_OFS_PORT1, {22'h0, t, r, f, 7'h0}, 32'h380);
    rdchk(CSFW_OFS_ALIAS, {20'h0, t, r, 1'b0, f, 8'h0}, 32'hD00);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, about twice the expected run
  initial begin
    #500000;
    bad_count++;
    report_and_stop();
  end

  initial begin : main
    logic [6:0] prev;
    int         tr[7];
    int         hi[7];
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ev = 16'h0;
    bad_count = 0;
    comparisons = 0;
    scans = 0;
    tr = '{default: 0};
    hi = '{default: 0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(CSFW_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h0, 32'hFFFFFFFF);
    rdchk(CSFW_OFS_PULSE, 32'h1, 32'hFFFF80C3);
    pulse(1);
    for (int k = 0; k < 3; k++) begin
      scan();
      rdchk(CSFW_OFS_PULSE, {27'h0, (k == 0) ? 2'b01 : 2'b10, 1'(scans % 2), 2'b01},
            32'h1F);
    end
    pulse(2);
    scan();
    rdchk(CSFW_OFS_PULSE, 32'h20, 32'h20);
    scan();
    rdchk(CSFW_OFS_PULSE, 32'h0, 32'h20);
    // pin is synchronised, so allow its settle delay
    lvl(4, 1'b1);
    repeat (4) @(posedge hclk);
    rdchk(CSFW_OFS_RUN, 32'h1, 32'h1);
    pulse(3);
    scan();
    rdchk(CSFW_OFS_PORT1, 32'h10, 32'h10);
    scan();
    rdchk(CSFW_OFS_PORT1, 32'h0, 32'h10);
    for (int v = 1; v >= 0; v--) begin
      lvl(6, 1'(v));
      lvl(7, 1'(v));
      lvl(8, 1'(v));
      lvl(11, 1'(v));
      rdchk(CSFW_OFS_RUN, (v == 1) ? 32'h4600 : 32'h0, 32'h4600);
      rdchk(CSFW_OFS_PORT1, (v == 1) ? 32'h8 : 32'h0, 32'h8);
    end
    pulse(5);
    rdchk(CSFW_OFS_RUN, 32'h40, 32'h40);
    pulse(9);
    rdchk(CSFW_OFS_RUN, 32'h8000, 32'hA000);
    pulse(10);
    rdchk(CSFW_OFS_RUN, 32'h2000, 32'hA000);
    bus(CSFW_OFS_CTRL, 1'b1, 32'h3);
    rdchk(CSFW_OFS_CTRL, 32'h3, 32'hFFFFFFFF);
    rdchk(CSFW_OFS_RUN, 32'h1000, 32'h1000);
    rdchk(CSFW_OFS_PORT1, 32'h4, 32'h4);
    rdchk(CSFW_OFS_ALIAS, 32'h200, 32'h200);
    bus(CSFW_OFS_PULSE, 1'b1, 32'hFFFFFFFF);
    rdchk(CSFW_OFS_PULSE, 32'h1, 32'hFFFF80C3);
    pulse(12);
    comm(1'b1, 1'b0, 1'b0);
    pulse(14);
    comm(1'b1, 1'b1, 1'b0);
    pulse(15);
    comm(1'b1, 1'b1, 1'b1);
    pulse(13);
    comm(1'b0, 1'b0, 1'b0);
    bus(CSFW_OFS_CTRL, 1'b1, 32'h0);
    rdchk(CSFW_OFS_RUN, 32'h0, 32'h1000);
    rdchk(CSFW_OFS_PORT1, 32'h0, 32'h4);
    rdchk(CSFW_OFS_ALIAS, 32'h0, 32'h200);
    lvl(4, 1'b0);
    repeat (4) @(posedge hclk);
    rdchk(CSFW_OFS_RUN, 32'h0, 32'h1);
    // sample every 2 cycles over 24000 cycles; halves are even, so no edge is lost
    bus(CSFW_OFS_PULSE, 1'b0, 32'h0);
    prev = rd[14:8];
    for (int n = 0; n < 12000; n++) begin
      bus(CSFW_OFS_PULSE, 1'b0, 32'h0);
      for (int i = 0; i < 7; i++) begin
        tr[i] += int'(rd[8+i] !== prev[i]);
        hi[i] += int'(rd[8+i] === 1'b1);
      end
      prev = rd[14:8];
    end
    for (int i = 0; i < 7; i++) begin
      chk(32'(tr[i] >= 24000 / H[i] - 1 && tr[i] <= 24000 / H[i] + 1),
          32'h1, 32'h1);
      chk(32'(hi[i] >= 6000 - H[i] / 2 - 1 && hi[i] <= 6000 + H[i] / 2 + 1), 32'h1, 32'h1);
    end
    report_and_stop();
  end

endmodule // csfw_top_test
